//--- remote_tx_model.sv
/*
 * Remote serial transmitter model feeding all four receive channels.
 * Assumes the bench requests characters and supplies the local reference tick.
 */
`timescale 1ns/10ps
module remote_tx_model (
	// Clock and requests
	input  wire logic        clk,
	input  wire logic        send,
	input  wire logic [9:0]  char_in,
	input  wire logic        ref_tick,
	input  wire logic [3:0]  stall,
	// Far side outputs
	output logic      [3:0]  char_strobe,
	output logic      [39:0] line_char,
	output logic      [3:0]  rec_tick
);
	// ==========================================
	// Character stream
	initial begin
		char_strobe = 4'h0;
		line_char   = 40'h0;
	end
	// One strobe per request; an idle line inverts its previous value every cycle
	always @(negedge clk) begin
		char_strobe <= {4{send}};
		line_char   <= send ? {4{char_in}} : ~line_char;
	end
	// Recovered clock follows the local reference; a stalled channel loses it
	assign rec_tick = {4{ref_tick}} & ~stall;
endmodule : remote_tx_model

//--- rxmon_pkg.sv
/*
 * Constants and types for the receive link monitor.
 * Assumes a 100 MHz core clock; reference and recovered clocks arrive as enables.
 */
package rxmon_pkg;
	// ==========================================
	// Clock and interval timing
	localparam int CORE_MHZ          = 100;
	localparam int INTERVAL_REF      = 16000;   // Reference periods per range sample
	localparam int RANGE_PPM         = 1500;    // Allowed VCO deviation
	localparam int FORCE_REF         = 100;     // Reference periods the VCO is held nominal
	// ==========================================
	// Amplitude trip levels in mV peak-to-peak
	localparam logic [9:0] AMP_LOW_MV  = 10'h08C;  // 140
	localparam logic [9:0] AMP_MID_MV  = 10'h118;  // 280
	localparam logic [9:0] AMP_HIGH_MV = 10'h1A4;  // 420
	localparam logic [1:0] SEL_LOW     = 2'h0;
	localparam logic [1:0] SEL_MID     = 2'h1;
	localparam logic [1:0] SEL_HIGH    = 2'h2;
	// ==========================================
	// Transition density counts
	localparam logic [2:0] QUIET_MAX   = 3'h6;     // Six characters without transitions
	localparam logic [1:0] GOOD_NEED   = 2'h3;     // Adjacent characters to clear
	// ==========================================
	// Framing characters, bit 0 received first
	localparam logic [9:0] K285_POS    = 10'h17C;
	localparam logic [9:0] K285_NEG    = 10'h283;
	localparam logic [7:0] COMMA_POS   = 8'h7C;
	localparam logic [7:0] COMMA_NEG   = 8'h83;
	// ==========================================
	// Reset values
	localparam logic [7:0] RX_EN_RST   = 8'h55;    // All receive channels enabled
	// ==========================================
	// Range control states
	typedef enum logic [1:0] {
		RC_MEASURE = 2'b01,
		RC_FORCE   = 2'b10
	} rc_state_t;
endpackage : rxmon_pkg

//--- serdes_rx_link_monitor.sv
/*
 * Receive link monitor and channel control for a four-channel deserializer.
 * Assumes characters, reference periods and recovered clock periods arrive as
 * core-clock enables; control pins are asynchronous and synchronised here.
 */
// How it works
// - Flag valid only when all four checks pass
// - Select picks 140, 280 or 420 mV
// - Over six quiet characters raises fault
// - Fault clears after three transition characters
// - Loopback feeds transmit; transmitters drive one
// - Loopback ignores amplitude, deselects line receiver
// - Out-of-range VCO forced nominal, then released
// - Sampling interval is 16000 reference periods
// - Flag held low while VCO forced
// - Lock expected within one sampling interval
// - Enable latch transparent while open, holds otherwise
// - Control bit high enables, low powers down
// - Disabled channel shows asserted fault flag
// - Reference at character or half character rate
// - Forced channel tracks reference, then data
// - Framer searches every position, sets boundary
// - Framing select chooses comma or K28.5
`timescale 1ns/10ps
module serdes_rx_link_monitor #(
	parameter int NUM_CH   = 4,
	parameter int INTERVAL = rxmon_pkg::INTERVAL_REF
) (
	// Clock and reset
	input  wire logic                 CORE_CLK,
	input  wire logic                 RST,
	// Asynchronous control pins
	input  wire logic [1:0]           AMPLITUDE_THRESHOLD_SELECT,
	input  wire logic [1:0]           FRAMING_CHAR_SELECT,
	input  wire logic                 TX_CLOCK_RATIO_SELECT,
	input  wire logic                 RX_ENABLE_LATCH_OPEN,
	input  wire logic [7:0]           CHANNEL_CONTROL_BUS,
	input  wire logic [NUM_CH-1:0]    LOCAL_LOOPBACK_ENABLE,
	input  wire logic [NUM_CH-1:0]    FRAMER_ENABLE,
	// Shared reference and per-channel front end, core clock domain
	input  wire logic                 REF_TICK,
	input  wire logic [NUM_CH-1:0]    RECOVERED_CHAR_TICK,
	input  wire logic [NUM_CH*10-1:0] AMP_MV,
	input  wire logic [NUM_CH-1:0]    CHAR_STROBE,
	input  wire logic [NUM_CH*10-1:0] SERIAL_LINE_CHAR,
	input  wire logic [NUM_CH*10-1:0] TX_CHAR,
	// Status and control outputs
	output logic [NUM_CH-1:0]         LINK_FAULT_FLAG_N,
	output logic [NUM_CH-1:0]         VCO_FORCE_NOMINAL,
	output logic [NUM_CH-1:0]         LINE_SELECT,
	output logic [NUM_CH-1:0]         CHANNEL_POWER_ON,
	output logic                      TX_FORCE_ONE,
	output logic [NUM_CH*10-1:0]      PAR_CHAR,
	output logic [NUM_CH-1:0]         PAR_VALID
);
	import rxmon_pkg::*;

	localparam int SW = 14 + 2 * NUM_CH;
	localparam int LIM1 = (INTERVAL * RANGE_PPM) / 1000000;

	// Framing character match at one bit position
	function automatic logic frame_hit(input logic [9:0] w, input logic [1:0] sel);
		if (sel == SEL_HIGH)
			return (w == K285_POS) || (w == K285_NEG);
		else if (sel == SEL_MID)
			return (w[7:0] == COMMA_POS) || (w[7:0] == COMMA_NEG);
		return 1'b0;
	endfunction : frame_hit

	// ==========================================
	// Pin synchroniser: three stages, change accepted when stages two and three agree
	logic [SW-1:0] s1_reg, s2_reg, s3_reg, pin_reg, pin_next;
	always_comb begin
		pin_next = (s2_reg == s3_reg) ? s3_reg : pin_reg;
	end
	always_ff @(posedge CORE_CLK or posedge RST) begin
		if (RST) begin
			s1_reg  <= '0;
			s2_reg  <= '0;
			s3_reg  <= '0;
			pin_reg <= '0;
		end else begin
			s1_reg  <= {AMPLITUDE_THRESHOLD_SELECT, FRAMING_CHAR_SELECT, TX_CLOCK_RATIO_SELECT,
				RX_ENABLE_LATCH_OPEN, CHANNEL_CONTROL_BUS, LOCAL_LOOPBACK_ENABLE, FRAMER_ENABLE};
			s2_reg  <= s1_reg;
			s3_reg  <= s2_reg;
			pin_reg <= pin_next;
		end
	end

	logic [1:0]        amp_sel, frm_sel;
	logic              ratio_hi, latch_open;
	logic [7:0]        bus;
	logic [NUM_CH-1:0] loop, fen;
	assign {amp_sel, frm_sel, ratio_hi, latch_open, bus, loop, fen} = pin_reg;

	// ==========================================
	// Receive channel enable latch
	logic [7:0] lat_reg, lat_next;
	always_comb begin
		lat_next = latch_open ? bus : lat_reg;
	end
	always_ff @(posedge CORE_CLK or posedge RST) begin
		if (RST)
			lat_reg <= RX_EN_RST;
		else
			lat_reg <= lat_next;
	end

	// ==========================================
	// Range control interval counter, one shared reference timebase
	logic [15:0] ivl_reg, ivl_next;
	logic        ivl_end;
	always_comb begin
		ivl_end  = REF_TICK && (ivl_reg == 16'(INTERVAL - 1));
		ivl_next = ivl_reg;
		if (REF_TICK)
			ivl_next = ivl_end ? 16'h0000 : ivl_reg + 16'h0001;
	end
	always_ff @(posedge CORE_CLK or posedge RST) begin
		if (RST)
			ivl_reg <= 16'h0000;
		else
			ivl_reg <= ivl_next;
	end

	// ==========================================
	// Per-channel state
	logic [NUM_CH-1:0] en, amp_ok, has_t, valid_c;
	rc_state_t   rc_reg     [NUM_CH], rc_next    [NUM_CH];
	logic [16:0] rec_reg    [NUM_CH], rec_next   [NUM_CH];
	logic [7:0]  frc_reg    [NUM_CH], frc_next   [NUM_CH];
	logic [2:0]  quiet_reg  [NUM_CH], quiet_next [NUM_CH];
	logic [1:0]  good_reg   [NUM_CH], good_next  [NUM_CH];
	logic [19:0] buf_reg    [NUM_CH], buf_next   [NUM_CH];
	logic [3:0]  off_reg    [NUM_CH], off_next   [NUM_CH];
	logic [NUM_CH-1:0] rok_reg, rok_next, df_reg, df_next, lb_reg, lb_next, arm_reg, arm_next;
	logic [NUM_CH-1:0] lfi_next, pv_next;
	logic [NUM_CH*10-1:0] pc_next;
	logic [16:0] expv, lim;
	logic [16:0] dev        [NUM_CH];
	logic [9:0]  ch_c, thr;

	// Monitor, range control, density and framer next-state logic
	always_comb begin
		expv = ratio_hi ? 17'(2 * INTERVAL) : 17'(INTERVAL);
		lim  = ratio_hi ? 17'(2 * LIM1) : 17'(LIM1);
		thr  = (amp_sel == SEL_LOW) ? AMP_LOW_MV :
			(amp_sel == SEL_HIGH) ? AMP_HIGH_MV : AMP_MID_MV;
		ch_c = 10'h000;
		pc_next = PAR_CHAR;
		for (int c = 0; c < NUM_CH; c++) begin
			en[c]       = lat_reg[2*c];
			amp_ok[c]   = loop[c] || (AMP_MV[c*10 +: 10] > thr);
			rc_next[c]  = rc_reg[c];
			rok_next[c] = rok_reg[c];
			frc_next[c] = frc_reg[c];
			rec_next[c] = rec_reg[c];
			arm_next[c] = arm_reg[c];
			if (RECOVERED_CHAR_TICK[c] && rec_reg[c] != 17'h1FFFF)
				rec_next[c] = rec_reg[c] + 17'h00001;
			// A tick on the interval end still belongs to the closing interval
			dev[c] = (rec_next[c] > expv) ? rec_next[c] - expv : expv - rec_next[c];
			unique case (rc_reg[c])
				RC_MEASURE: begin
					if (ivl_end) begin
						rec_next[c] = 17'h00000;
						arm_next[c] = 1'b1;
						if (arm_reg[c]) begin
							rok_next[c] = (dev[c] <= lim);
							if (dev[c] > lim) begin
								rc_next[c]  = RC_FORCE;
								rok_next[c] = 1'b0;
								frc_next[c] = 8'h00;
							end
						end
					end
				end
				RC_FORCE: begin
					rec_next[c] = 17'h00000;
					if (REF_TICK)
						frc_next[c] = frc_reg[c] + 8'h01;
					if (REF_TICK && frc_reg[c] == 8'(FORCE_REF - 1)) begin
						rc_next[c]  = RC_MEASURE;
						arm_next[c] = ivl_end;                       // Partial count is not judged
					end
				end
			endcase
			if (!en[c]) begin
				rc_next[c]  = RC_MEASURE;
				rok_next[c] = 1'b0;
				rec_next[c] = 17'h00000;
				arm_next[c] = 1'b0;
			end
			// Transition density over received or looped characters
			ch_c        = loop[c] ? TX_CHAR[c*10 +: 10] : SERIAL_LINE_CHAR[c*10 +: 10];
			has_t[c]    = (ch_c != 10'h000 && ch_c != 10'h3FF) || (ch_c[0] != buf_reg[c][19]);
			quiet_next[c] = quiet_reg[c];
			good_next[c]  = good_reg[c];
			df_next[c]    = df_reg[c];
			buf_next[c]   = buf_reg[c];
			off_next[c]   = off_reg[c];
			pv_next[c]    = 1'b0;
			if (CHAR_STROBE[c]) begin
				if (!has_t[c]) begin
					good_next[c] = 2'h0;
					if (quiet_reg[c] == QUIET_MAX)
						df_next[c] = 1'b1;
					else
						quiet_next[c] = quiet_reg[c] + 3'h1;
				end else begin
					quiet_next[c] = 3'h0;
					if (df_reg[c]) begin
						good_next[c] = good_reg[c] + 2'h1;
						if (good_reg[c] == GOOD_NEED - 2'h1) begin
							df_next[c]   = 1'b0;
							good_next[c] = 2'h0;
						end
					end
				end
				// Framer: newest character in the high half
				buf_next[c] = {ch_c, buf_reg[c][19:10]};
				if (fen[c])
					for (int i = 9; i >= 0; i--)
						if (frame_hit(buf_next[c][i +: 10], frm_sel))
							off_next[c] = 4'(i);
				pc_next[c*10 +: 10] = buf_next[c][off_next[c] +: 10];
				pv_next[c] = en[c];
			end
			valid_c[c]  = en[c] && amp_ok[c] && !df_reg[c] && rok_reg[c] && (rc_reg[c] == RC_MEASURE);
			lfi_next[c] = valid_c[c];
			lb_next[c]  = en[c] && !loop[c];
		end
	end

	always_ff @(posedge CORE_CLK or posedge RST) begin
		if (RST) begin
			for (int c = 0; c < NUM_CH; c++) begin
				rc_reg[c]    <= RC_MEASURE;
				rec_reg[c]   <= 17'h00000;
				frc_reg[c]   <= 8'h00;
				quiet_reg[c] <= 3'h0;
				good_reg[c]  <= 2'h0;
				buf_reg[c]   <= 20'h00000;
				off_reg[c]   <= 4'h0;
			end
			rok_reg           <= '0;
			arm_reg           <= '1;
			df_reg            <= '0;
			lb_reg            <= '0;
			LINK_FAULT_FLAG_N <= '0;
			PAR_CHAR          <= '0;
			PAR_VALID         <= '0;
			TX_FORCE_ONE      <= 1'b0;
		end else begin
			for (int c = 0; c < NUM_CH; c++) begin
				rc_reg[c]    <= rc_next[c];
				rec_reg[c]   <= rec_next[c];
				frc_reg[c]   <= frc_next[c];
				quiet_reg[c] <= quiet_next[c];
				good_reg[c]  <= good_next[c];
				buf_reg[c]   <= buf_next[c];
				off_reg[c]   <= off_next[c];
			end
			rok_reg           <= rok_next;
			arm_reg           <= arm_next;
			df_reg            <= df_next;
			lb_reg            <= lb_next;
			LINK_FAULT_FLAG_N <= lfi_next;
			PAR_CHAR          <= pc_next;
			PAR_VALID         <= pv_next;
			TX_FORCE_ONE      <= |loop;
		end
	end

	// Channel control outputs
	always_comb begin
		for (int c = 0; c < NUM_CH; c++) begin
			VCO_FORCE_NOMINAL[c] = (rc_reg[c] == RC_FORCE);
			CHANNEL_POWER_ON[c]  = en[c];
		end
		LINE_SELECT = lb_reg;
	end

	// ==========================================
	// Assertions on channel 0, the interval counter and the enable latch
	default clocking cb @(posedge CORE_CLK); endclocking
	default disable iff (RST);

	property p_valid;
		LINK_FAULT_FLAG_N[0] |-> $past(en[0] && amp_ok[0] && !df_reg[0] && rok_reg[0]);
	endproperty
	a_valid: assert property (p_valid) else $error("flag valid without all checks");
	property p_amp;
		!loop[0] && AMP_MV[9:0] <= thr && $stable(amp_sel) |=> !LINK_FAULT_FLAG_N[0];
	endproperty
	a_amp: assert property (p_amp) else $error("flag valid below amplitude threshold");
	property p_quiet;
		CHAR_STROBE[0] && !has_t[0] && quiet_reg[0] == QUIET_MAX |=> df_reg[0] ##1 !LINK_FAULT_FLAG_N[0];
	endproperty
	a_quiet: assert property (p_quiet) else $error("quiet span did not fault");
	property p_clear;
		$fell(df_reg[0]) |-> $past(good_reg[0]) == 2'h2 && $past(has_t[0] && CHAR_STROBE[0]);
	endproperty
	a_clear: assert property (p_clear) else $error("density fault cleared early");
	property p_loop;
		loop[0] |=> TX_FORCE_ONE && !LINE_SELECT[0];
	endproperty
	a_loop: assert property (p_loop) else $error("loopback outputs wrong");
	property p_force;
		ivl_end && rc_reg[0] == RC_MEASURE && en[0] && arm_reg[0] && dev[0] > lim
			|=> VCO_FORCE_NOMINAL[0] ##1 !LINK_FAULT_FLAG_N[0];
	endproperty
	a_force: assert property (p_force) else $error("out-of-range VCO not forced");
	property p_ivl;
		ivl_end |=> ivl_reg == 16'h0000 ##1 ivl_reg <= 16'(INTERVAL - 1);
	endproperty
	a_ivl: assert property (p_ivl) else $error("interval counter wrong");
	property p_hold;
		VCO_FORCE_NOMINAL[0] |=> !LINK_FAULT_FLAG_N[0];
	endproperty
	a_hold: assert property (p_hold) else $error("flag valid while forced");
	property p_latch;
		!latch_open |=> $stable(lat_reg);
	endproperty
	a_latch: assert property (p_latch) else $error("closed latch changed");
	property p_dis;
		!en[0] |=> !LINK_FAULT_FLAG_N[0];
	endproperty
	a_dis: assert property (p_dis) else $error("disabled channel shows valid");

	c_valid: cover property ($rose(LINK_FAULT_FLAG_N[0]));
	c_force: cover property ($rose(VCO_FORCE_NOMINAL[0]));
	c_frame: cover property (CHAR_STROBE[0] && fen[0] && off_next[0] != off_reg[0]);
endmodule : serdes_rx_link_monitor

//--- serdes_rx_link_monitor_tb_top.sv
/*
 * Self-checking bench for the receive link monitor.
 * Assumes the remote transmitter model and a short range interval.
 */
`timescale 1ns/10ps
module serdes_rx_link_monitor_tb_top;
	import rxmon_pkg::*;
	localparam int IVL = 20;
	logic        core_clk, rst, ref_tick, send, latch_open, ratio;
	logic [1:0]  amp_sel, frame_sel;
	logic [3:0]  stall, loopback, framer_en, strobe, rtick;
	logic [3:0]  flag_n, vco_force, line_sel, power_on, par_valid;
	logic [7:0]  bus;
	logic [9:0]  char_in;
	logic [39:0] amp, line_char, tx_char, par_char;
	logic        tx_one;
	int          errors, total_checks, i;
	logic [1:0]  sel_t [7] = '{SEL_LOW, SEL_LOW, SEL_MID, SEL_MID, SEL_HIGH, SEL_HIGH, 2'h3};
	logic [9:0]  amp_t [7] = '{10'h096, 10'h082, 10'h122, 10'h10E, 10'h1AE, 10'h19A, 10'h122};
	logic [6:0]  ok_t = 7'b1010101;
	// ==========================================
	// Clock, reference and instances
	always #5 core_clk = ~core_clk;
	always @(negedge core_clk) ref_tick <= rst ? 1'b0 : ~ref_tick;
	remote_tx_model u_remote_tx_model (.clk(core_clk), .send(send), .char_in(char_in), .ref_tick(ref_tick),
		.stall(stall), .char_strobe(strobe), .line_char(line_char), .rec_tick(rtick));
	serdes_rx_link_monitor #(.INTERVAL(IVL)) u_serdes_rx_link_monitor (.CORE_CLK(core_clk), .RST(rst),
		.AMPLITUDE_THRESHOLD_SELECT(amp_sel), .FRAMING_CHAR_SELECT(frame_sel), .TX_CLOCK_RATIO_SELECT(ratio),
		.RX_ENABLE_LATCH_OPEN(latch_open), .CHANNEL_CONTROL_BUS(bus), .LOCAL_LOOPBACK_ENABLE(loopback),
		.FRAMER_ENABLE(framer_en), .REF_TICK(ref_tick), .RECOVERED_CHAR_TICK(rtick), .AMP_MV(amp),
		.CHAR_STROBE(strobe), .SERIAL_LINE_CHAR(line_char), .TX_CHAR(tx_char), .LINK_FAULT_FLAG_N(flag_n),
		.VCO_FORCE_NOMINAL(vco_force), .LINE_SELECT(line_sel), .CHANNEL_POWER_ON(power_on),
		.TX_FORCE_ONE(tx_one), .PAR_CHAR(par_char), .PAR_VALID(par_valid));
	// ==========================================
	// Tasks
	task automatic check(input logic [39:0] seen, input logic [39:0] exp);
		total_checks++;
		if (seen !== exp) begin
			errors++;
			$display("unexpected at %0t: got %h want %h", $time, seen, exp);
		end
	endtask : check
	task automatic finish_test;
		$display("checks %0d errors %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : finish_test
	task automatic ticks(input int n);
		repeat (n) @(negedge core_clk);
	endtask : ticks
	task automatic send_char(input logic [9:0] c);
		@(negedge core_clk);
		send    <= 1'b1;
		char_in <= c;
		@(negedge core_clk);
		send    <= 1'b0;
	endtask : send_char
	// Bounded wait for a flag pattern; a timeout ends the run
	task automatic wait_flag(input logic [3:0] exp, input int lim);
		int k;
		for (k = 0; k < lim && flag_n !== exp; k++) ticks(1);
		check(flag_n, exp);
		if (flag_n !== exp) finish_test();
	endtask : wait_flag
	// Bounded wait for a forced-VCO pattern; a timeout ends the run
	task automatic wait_force(input logic [3:0] exp, input int lim);
		int k;
		for (k = 0; k < lim && vco_force !== exp; k++) ticks(1);
		check(vco_force, exp);
		if (vco_force !== exp) finish_test();
	endtask : wait_force
	// Three chars with the framing char at bit offset sh; off is the expected boundary
	task automatic frame(input logic [1:0] sel, input logic [9:0] fc, input int sh, input int off);
		logic [42:0] t;
		logic [39:0] s;
		int          k;
		t = {10'h155, 10'h155, 10'h2B3, fc, 3'b101};
		s = 40'(t >> (3 - sh));
		frame_sel = sel;
		ticks(6);
		for (k = 0; k < 3; k++) send_char(s[k*10 +: 10]);
		ticks(1);
		check(par_valid, 4'hF);
		ticks(2);
		check(par_char[9:0], s[10+off +: 10]);
	endtask : frame
	// ==========================================
	// Main sequence
	initial begin
		core_clk = 1'b0; rst = 1'b1; ref_tick = 1'b0; send = 1'b0; char_in = 10'h155;
		amp_sel = SEL_MID; frame_sel = 2'h0; latch_open = 1'b1; bus = 8'h55; stall = 4'h0;
		loopback = 4'h0; framer_en = 4'h0; amp = {4{10'h1F4}}; tx_char = {4{10'h155}};
		errors = 0; total_checks = 0; ratio = 1'b0;
		ticks(8);
		check(power_on, 4'hF);
		check(flag_n, 4'h0);
		rst = 1'b0;
		wait_flag(4'hF, 200);
		// Amplitude trip levels on channel 0
		for (i = 0; i < 7; i++) begin
			amp_sel = sel_t[i];
			amp[9:0] = amp_t[i];
			ticks(8);
			check(flag_n, {3'b111, ok_t[6-i]});
		end
		amp[9:0] = 10'h1F4;
		amp_sel = SEL_MID;
		// Quiet characters, then recovery
		send_char(10'h155);
		for (i = 0; i < 7; i++) begin
			send_char(10'h000);
			ticks(4);
			check(flag_n, (i < 6) ? 4'hF : 4'h0);
		end
		for (i = 0; i < 3; i++) begin
			send_char(10'h155);
			ticks(4);
			check(flag_n, (i < 2) ? 4'h0 : 4'hF);
		end
		// Channel 2 loses its recovered clock
		stall = 4'b0100;
		wait_force(4'b0100, 50);
		ticks(2);
		check(flag_n, 4'b1011);
		stall = 4'h0;
		for (i = 0; i < 250 && vco_force[2] !== 1'b0; i++) ticks(1);
		check(40'((i + 5) / 10), 40'd20);
		if (i == 250) finish_test();
		wait_flag(4'hF, 100);
		// Reference declared half rate: every channel counts too few and is forced
		ratio = 1'b1;
		wait_force(4'hF, 60);
		ratio = 1'b0;
		ticks(2);
		check(flag_n, 4'h0);
		wait_force(4'h0, 250);
		wait_flag(4'hF, 100);
		// Enable latch
		bus = 8'h51;
		ticks(6);
		check(power_on, 4'b1101);
		ticks(2);
		check(flag_n, 4'b1101);
		latch_open = 1'b0;
		ticks(6);
		bus = 8'hAA;
		ticks(6);
		check(power_on, 4'b1101);
		latch_open = 1'b1;
		ticks(8);
		check({power_on, flag_n}, 8'h00);
		bus = 8'h55;
		wait_flag(4'hF, 300);
		// Local loopback on channel 0 with no line amplitude
		loopback = 4'b0001;
		amp[9:0] = 10'h000;
		ticks(7);
		check({tx_one, line_sel}, 5'h1E);
		for (i = 0; i < 4; i++) send_char(10'h155);
		ticks(4);
		check(flag_n, 4'hF);
		loopback = 4'h0;
		ticks(8);
		check({tx_one, line_sel, flag_n}, 9'h0FE);
		amp[9:0] = 10'h1F4;
		// Framer search and character selection
		framer_en = 4'hF;
		frame(2'h2, K285_POS, 0, 0);
		frame(2'h2, 10'h37C, 3, 0);
		frame(2'h1, 10'h37C, 3, 3);
		finish_test();
	end
endmodule : serdes_rx_link_monitor_tb_top
